// file: arsr_readout.sv
// Serial result readout: formatting, shift-out, status and serial programming
// Function
// [R1] Each result leaves as exactly one 32-bit serial word.
// [R2] Word is three status bits, 24 result bits MSB first, five sub-LSB bits.
// [R3] Bit 31 is pending flag: high while converting, low when done.
// [R4] Bit 30 is a filler bit, always low.
// [R5] Bit 29 high for zero or positive input, low for negative.
// [R6] Bits 29 and 28 both high is over-range, both low under-range.
// [R7] Bits 28 down to 5 carry the 24-bit result, bit 5 its LSB.
// [R8] Bits 4 down to 0 carry extra resolution below 24 bits.
// [R9] Chip select high: output released and serial clock ignored.
// [R10] Chip select low: output shows pending flag, falls when conversion ends.
// [R11] Host takes bit 31 on first rise; bit 30 on first fall onward.
// [R12] Bit 0 goes out on the 31st fall, sampled on 32nd rise.
// [R13] The 32nd fall drives output high and starts a new conversion.
// [R14] Over-range clamps to full scale plus one LSB, under-range to minus one.
// [R15] Offset coding: zero is polarity high, rest zero; minus one LSB all ones.
// [R16] Link polls status in conversion and sleep, reads and programs in output.
// [R17] Chip select rising during output aborts and starts a new conversion.
// [R18] Output changes on falling edges; host samples on rising edges.
// [R19] Host shifts prefix 101 to update settings; 000 or 100 keeps them.
// [R20] Clock source select low takes host clock, high drives own clock.
// [R21] Word latched at conversion end, held until shifted out or aborted.
`include "arsr_map.svh"
`timescale 1ns/100ps
`default_nettype none
module arsr_readout (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Serial link pins
  input wire logic cs_n,
  input wire logic sdi,
  input wire logic sck_in,
  output logic sck_out,
  output logic sck_oe,
  output logic sdo_out,
  output logic sdo_oe,
  // Clock source pin
  input wire logic clock_source_select,
  // Converter core side
  output logic conv_start,
  input wire logic res_valid,
  output logic res_ready,
  input wire logic [`ARSR_SAMPLE_BITS-1:0] res_sample,
  // Settings for the next conversion
  output logic [4:0] cfg_channel,
  output logic [4:0] cfg_speed,
  output logic cfg_update
);
  localparam logic [2:0] SCK_HALF = 3'(`ARSR_SCK_HALF_CYC);

  arsr_pkg::arsr_state_t state;
  arsr_pkg::arsr_state_t next_state;
  logic [3:0] pins_sync;
  logic cs_s;
  logic sck_s;
  logic sel_s;
  logic sdi_s;
  logic cs_d;
  logic sck_d;
  logic [2:0] div_cnt;
  logic sck_gen;
  logic [31:0] shreg;
  logic [5:0] fall_cnt;
  logic [12:0] cfg_shift;
  logic [3:0] in_cnt;
  logic first_start;
  logic buf_valid;
  logic [`ARSR_SAMPLE_BITS-1:0] buf_sample;
  logic [1:0] sync_warm;

  // Pin synchronisers
  arsr_sync2 #(
    .WIDTH(4)
  ) u_sync (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .async_in({clock_source_select, sdi, sck_in, cs_n}),
    .sync_out(pins_sync)
  );

  assign cs_s = pins_sync[0] || !sync_warm[1]; // R9
  assign sck_s = pins_sync[1];
  assign sdi_s = pins_sync[2];
  assign sel_s = pins_sync[3];

  // Deselected until both sync stages hold real pin levels
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sync_warm <= 2'h0;
    end else begin
      sync_warm <= {sync_warm[0], 1'b1};
    end
  end

  // Result buffer; drained only while converting
  wire buf_ready = (state == arsr_pkg::st_convert);

  arsr_pair_buf #(
    .WIDTH(`ARSR_SAMPLE_BITS)
  ) u_buf (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .in_valid(res_valid),
    .in_ready(res_ready),
    .in_data(res_sample),
    .out_valid(buf_valid),
    .out_ready(buf_ready),
    .out_data(buf_sample)
  );

  // Result formatting with clamping and offset coding
  wire over = $signed(buf_sample) > $signed(`ARSR_POS_CLAMP); // R14
  wire under = $signed(buf_sample) < $signed(`ARSR_NEG_CLAMP); // R14
  wire [29:0] clamped = over ? `ARSR_POS_CLAMP : (under ? `ARSR_NEG_CLAMP : buf_sample);
  wire [31:0] word_fmt = {1'b0, 1'b0, ~clamped[29], clamped[28:0]}; // R2 R4 R5 R6 R7 R8 R15
  wire load = buf_valid && buf_ready;

  // Serial clock events from host pin or own divider
  wire int_run = sel_s && !cs_s && (state != arsr_pkg::st_convert);
  wire int_tick = int_run && (div_cnt == SCK_HALF - 3'h1);
  wire ext_rise = sck_s && !sck_d;
  wire ext_fall = !sck_s && sck_d;
  wire rise = !cs_s && (sel_s ? (int_tick && !sck_gen) : ext_rise); // R9 R20
  wire fall = !cs_s && (sel_s ? (int_tick && sck_gen) : ext_fall); // R9 R20 R18
  wire cs_rise = cs_s && !cs_d;
  wire in_output = (state == arsr_pkg::st_output);
  wire last_fall = in_output && fall && (fall_cnt == `ARSR_LAST_FALL); // R1 R12
  wire abort = in_output && cs_rise; // R17
  wire leave_output = last_fall || abort;
  wire take_sdi = rise && (in_output || state == arsr_pkg::st_sleep) && (in_cnt < `ARSR_CFG_BITS);
  wire cfg_hit = (in_cnt == `ARSR_CFG_BITS) && (cfg_shift[12:10] == `ARSR_PREFIX_UPDATE); // R19

  always_comb begin
    next_state = state;
    unique case (state)
      arsr_pkg::st_convert: begin
        if (load) begin
          next_state = arsr_pkg::st_sleep;
        end
      end
      arsr_pkg::st_sleep: begin
        if (rise) begin
          next_state = arsr_pkg::st_output; // R11
        end
      end
      arsr_pkg::st_output: begin
        if (leave_output) begin
          next_state = arsr_pkg::st_convert; // R13 R17
        end
      end
      default: begin
        next_state = arsr_pkg::st_convert;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= arsr_pkg::st_convert;
      cs_d <= 1'b1;
      sck_d <= 1'b0;
    end else begin
      state <= next_state;
      cs_d <= cs_s;
      sck_d <= sck_s;
    end
  end

  // Own serial clock divider
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      div_cnt <= 3'h0;
      sck_gen <= 1'b0;
    end else if (!int_run) begin
      div_cnt <= 3'h0;
      sck_gen <= 1'b0;
    end else if (int_tick) begin
      div_cnt <= 3'h0;
      sck_gen <= ~sck_gen; // R20
    end else begin
      div_cnt <= div_cnt + 3'h1;
    end
  end

  // Output shift register and bit counter
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      shreg <= 32'hFFFF_FFFF;
      fall_cnt <= 6'h00;
    end else if (load) begin
      shreg <= word_fmt; // R21
      fall_cnt <= 6'h00;
    end else if (in_output && fall) begin
      shreg <= {shreg[30:0], 1'b1}; // R11 R18
      fall_cnt <= fall_cnt + 6'h01;
    end
  end

  // Serial output pin; pending flag outside the output state
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sdo_out <= 1'b1;
      sdo_oe <= 1'b0;
    end else begin
      sdo_out <= in_output ? shreg[`ARSR_BIT_PENDING] : (state == arsr_pkg::st_convert); // R3 R10
      sdo_oe <= !cs_s; // R9
    end
  end

  assign sck_out = sck_gen;
  assign sck_oe = sel_s; // R20

  // Conversion start, including the one after reset
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      first_start <= 1'b1;
      conv_start <= 1'b0;
    end else begin
      first_start <= 1'b0;
      conv_start <= first_start || leave_output; // R13 R17
    end
  end

  // Serial input capture and settings update
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_shift <= 13'h0000;
      in_cnt <= 4'h0;
      cfg_channel <= `ARSR_CHANNEL_RST;
      cfg_speed <= `ARSR_SPEED_RST;
      cfg_update <= 1'b0;
    end else begin
      cfg_update <= 1'b0;
      if (state == arsr_pkg::st_convert) begin
        in_cnt <= 4'h0;
      end else if (take_sdi) begin
        cfg_shift <= {cfg_shift[11:0], sdi_s}; // R16
        in_cnt <= in_cnt + 4'h1;
      end
      if (leave_output && cfg_hit) begin
        cfg_channel <= cfg_shift[9:5]; // R19
        cfg_update <= 1'b1;
        if (cfg_shift[4:0] != 5'h00) begin
          cfg_speed <= cfg_shift[4:0];
        end
      end
    end
  end

  // Checks
  wire shreg_second = shreg[30];

  AST_OE_RELEASED: assert property (@(posedge ref_clk) disable iff (!reset_n) // R9
    cs_s |=> !sdo_oe)
    else $error("serial output driven with chip select high");
  AST_IGNORE_SCK: assert property (@(posedge ref_clk) disable iff (!reset_n) // R9
    (cs_s && state == arsr_pkg::st_sleep) |=> state == arsr_pkg::st_sleep)
    else $error("serial clock acted on with chip select high");
  AST_EOC_FALLS: assert property (@(posedge ref_clk) disable iff (!reset_n) // R10
    (load && !cs_s) |-> ##2 (!sdo_out || !$past(cs_s, 1) && cs_s))
    else $error("pending flag did not fall after conversion end");
  AST_PENDING_HIGH: assert property (@(posedge ref_clk) disable iff (!reset_n) // R3
    (state == arsr_pkg::st_convert) [*2] |-> sdo_out)
    else $error("pending flag low during conversion");
  AST_FILLER_LOW: assert property (@(posedge ref_clk) disable iff (!reset_n) // R4
    (in_output && fall && fall_cnt == 6'h00) |-> ##2 (!sdo_out || !in_output))
    else $error("filler bit not low");
  AST_WORD_LEN: assert property (@(posedge ref_clk) disable iff (!reset_n) // R1
    (in_output && fall && fall_cnt == 6'h1F) |=> state == arsr_pkg::st_convert ##1 sdo_out)
    else $error("word did not end with output high after 32 falls");
  AST_ABORT: assert property (@(posedge ref_clk) disable iff (!reset_n) // R17
    (in_output && cs_rise) |=> (state == arsr_pkg::st_convert && conv_start))
    else $error("abort did not start a conversion");
  AST_START_PULSE: assert property (@(posedge ref_clk) disable iff (!reset_n) // R13
    conv_start |=> !conv_start)
    else $error("conversion start longer than one cycle");
  AST_CLAMP_HI: assert property (@(posedge ref_clk) disable iff (!reset_n) // R14
    (buf_valid && over) |-> word_fmt[29:0] == 30'h3000_0000)
    else $error("over-range not clamped");
  AST_CLAMP_LO: assert property (@(posedge ref_clk) disable iff (!reset_n) // R14
    (buf_valid && under) |-> word_fmt[29:0] == 30'h0FFF_FFFF)
    else $error("under-range not clamped");
  AST_ZERO_CODE: assert property (@(posedge ref_clk) disable iff (!reset_n) // R15
    (buf_valid && buf_sample == 30'h0000_0000) |-> word_fmt == 32'h2000_0000)
    else $error("zero input code wrong");
  AST_WORD_HELD: assert property (@(posedge ref_clk) disable iff (!reset_n) // R21
    (state == arsr_pkg::st_sleep && $past(state) == arsr_pkg::st_sleep) |-> $stable(shreg))
    else $error("latched word changed in sleep");
  AST_OWN_CLOCK: assert property (@(posedge ref_clk) disable iff (!reset_n) // R20
    (!sel_s) |-> ##1 !sck_gen)
    else $error("own serial clock toggles in host clock mode");
  AST_BIT_ORDER: assert property (@(posedge ref_clk) disable iff (!reset_n) // R11 R18
    (in_output && fall && !cs_rise && fall_cnt != 6'h1F) |-> ##2 (sdo_out == $past(shreg_second, 2)))
    else $error("serial output did not show the next word bit after a fall");
  AST_CFG_KEEP: assert property (@(posedge ref_clk) disable iff (!reset_n) // R19
    (leave_output && !cfg_hit) |=> ($stable(cfg_channel) && $stable(cfg_speed)))
    else $error("settings changed without update prefix");
  AST_OE_DRIVEN: assert property (@(posedge ref_clk) disable iff (!reset_n) // R10
    (!cs_s) |=> sdo_oe)
    else $error("serial output released with chip select low");

  COV_FULL_READ: cover property (@(posedge ref_clk) disable iff (!reset_n)
    last_fall && !sel_s);
  COV_INT_READ: cover property (@(posedge ref_clk) disable iff (!reset_n)
    last_fall && sel_s);
  COV_ABORT: cover property (@(posedge ref_clk) disable iff (!reset_n)
    abort);
  COV_UPDATE: cover property (@(posedge ref_clk) disable iff (!reset_n)
    cfg_update);
  COV_OVER_RANGE: cover property (@(posedge ref_clk) disable iff (!reset_n)
    load && over);
endmodule
`default_nettype wire

// file: arsr_map.svh
// Offsets-free constant map for the serial result readout block
`ifndef ARSR_MAP_SVH
`define ARSR_MAP_SVH

// Output word layout
`define ARSR_WORD_LEN 32
`define ARSR_BIT_PENDING 31
`define ARSR_BIT_FILLER 30
`define ARSR_BIT_POLARITY 29
`define ARSR_SAMPLE_BITS 30
`define ARSR_LAST_FALL 6'h1F

// Clamp codes in two's complement sub-LSB units
`define ARSR_POS_CLAMP 30'h1000_0000
`define ARSR_NEG_CLAMP 30'h2FFF_FFFF

// Serial input programming
`define ARSR_CFG_BITS 4'hD
`define ARSR_PREFIX_UPDATE 3'h5
`define ARSR_CHANNEL_RST 5'h00
`define ARSR_SPEED_RST 5'h00

// Internal serial clock timing
`define ARSR_CLK_NS 50
`define ARSR_SCK_HALF_NS 200
`define ARSR_SCK_HALF_CYC ((`ARSR_SCK_HALF_NS + `ARSR_CLK_NS - 1) / `ARSR_CLK_NS)

`endif

// file: arsr_pkg.sv
// Types shared by the serial result readout block
package arsr_pkg;
  typedef enum logic [1:0] {
    st_convert = 2'h0,
    st_sleep = 2'h1,
    st_output = 2'h3
  } arsr_state_t;
endpackage

// file: arsr_sync2.sv
// Two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/100ps
`default_nettype none
module arsr_sync2 #(
  parameter int WIDTH = 4
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Pins in, synchronised out
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      stage1 <= '0;
      sync_out <= '0;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end
endmodule
`default_nettype wire

// file: arsr_pair_buf.sv
// Two-entry result buffer with valid and ready on both sides
`timescale 1ns/100ps
`default_nettype none
module arsr_pair_buf #(
  parameter int WIDTH = 30
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  logic [WIDTH-1:0] mem [0:1];
  logic wr_ptr;
  logic rd_ptr;
  logic [1:0] count;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  assign in_ready = (count != 2'h2);
  assign out_valid = (count != 2'h0);
  assign out_data = mem[rd_ptr];

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr <= ~wr_ptr;
      end
      if (pop) begin
        rd_ptr <= ~rd_ptr;
      end
      count <= count + {1'b0, push} - {1'b0, pop};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
endmodule
`default_nettype wire

// file: arsr_host_model.sv
// Host serial master model: chip select, serial clock and data in
`timescale 1ns/100ps
`default_nettype none
module arsr_host_model (
  // Lines seen from the device
  input wire logic sdo_line,
  input wire logic sck_line,
  input wire logic own_clk,
  // Lines driven by the host
  output logic cs_n,
  output logic sck,
  output logic sdi
);
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    sdi = 1'b0;
  end
  // Pin moves off the device clock's grid
  task automatic select(input logic level);
    #13;
    cs_n = level;
  endtask
  // Shifts n bits, command MSB first; clock stands still outside frames
  task automatic xfer(input int n, input logic [12:0] cmd, output logic [31:0] word);
    word = '1;
    for (int i = 0; i < n; i++) begin
      sdi = (i < 13) ? cmd[12-i] : 1'b0;
      if (own_clk) @(posedge sck_line);
      else begin
        #250;
        sck = 1'b1;
      end
      word = {word[30:0], sdo_line};
      if (own_clk) @(negedge sck_line);
      else begin
        #150;
        sck = 1'b0;
      end
    end
  endtask
endmodule
`default_nettype wire

// file: tb_top.sv
// Self-checking bench for the serial result readout block
`timescale 1ns/100ps
`default_nettype none
`include "arsr_map.svh"
module tb_top;
  typedef struct packed {
    logic [29:0] s;
    logic [31:0] w;
    logic [12:0] cmd;
    logic [4:0] ch;
    logic [4:0] sp;
  } arsr_row_t;
  logic ref_clk, reset_n, res_valid, clock_source_select, cs_n, sdi, sck;
  logic sck_out, sck_oe, sdo_out, sdo_oe, conv_start, res_ready, cfg_update;
  logic [`ARSR_SAMPLE_BITS-1:0] res_sample;
  logic [4:0] cfg_channel, cfg_speed;
  logic sdo_last = 1'b0;
  logic sdo_line, sck_line;
  logic [31:0] w;
  int n_fail, compares;
  int n_upd = 0;
  arsr_row_t rows [10] = '{
    '{30'h0000_0000, 32'h2000_0000, 13'h1467, 5'h03, 5'h07},
    '{30'h3FFF_FFFF, 32'h1FFF_FFFF, 13'h03FF, 5'h03, 5'h07},
    '{30'h0FFF_FFFF, 32'h2FFF_FFFF, 13'h114A, 5'h03, 5'h07},
    '{30'h1000_0000, 32'h3000_0000, 13'h1620, 5'h11, 5'h07},
    '{30'h1FFF_FFFF, 32'h3000_0000, 13'h0000, 5'h11, 5'h07},
    '{30'h3000_0000, 32'h1000_0000, 13'h0000, 5'h11, 5'h07},
    '{30'h2FFF_FFFF, 32'h0FFF_FFFF, 13'h0000, 5'h11, 5'h07},
    '{30'h2000_0000, 32'h0FFF_FFFF, 13'h0000, 5'h11, 5'h07},
    '{30'h0800_0000, 32'h2800_0000, 13'h0000, 5'h11, 5'h07},
    '{30'h0000_0015, 32'h2000_0015, 13'h0000, 5'h11, 5'h07}
  };
  // Released output line shows the inverse of its last driven level
  always @(sdo_out or sdo_oe) if (sdo_oe === 1'b1) sdo_last = sdo_out;
  assign sdo_line = (sdo_oe === 1'b1) ? sdo_out : ~sdo_last;
  assign sck_line = (sck_oe === 1'b1) ? sck_out : sck;
  // Settings update pulses seen
  always @(posedge ref_clk) if (cfg_update === 1'b1) n_upd++;
  arsr_readout dut_u (
    .ref_clk(ref_clk), .reset_n(reset_n), .cs_n(cs_n), .sdi(sdi), .sck_in(sck_line),
    .sck_out(sck_out), .sck_oe(sck_oe), .sdo_out(sdo_out), .sdo_oe(sdo_oe),
    .clock_source_select(clock_source_select), .conv_start(conv_start),
    .res_valid(res_valid), .res_ready(res_ready), .res_sample(res_sample),
    .cfg_channel(cfg_channel), .cfg_speed(cfg_speed), .cfg_update(cfg_update)
  );
  arsr_host_model host_u (
    .sdo_line(sdo_line), .sck_line(sck_line), .own_clk(clock_source_select),
    .cs_n(cs_n), .sck(sck), .sdi(sdi)
  );
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  task automatic finish_test();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    #1000000;
    n_fail++;
    finish_test();
  end
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Ends just past the edge so outputs have settled
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  // Hold valid until ready is seen at an edge
  task automatic push(input logic [29:0] s);
    @(posedge ref_clk);
    res_valid <= 1'b1;
    res_sample <= s;
    for (int i = 0; i < 50; i++) begin
      @(negedge ref_clk);
      if (res_ready === 1'b1) break;
    end
    @(posedge ref_clk);
    res_valid <= 1'b0;
  endtask
  task automatic wait_start(input string name);
    logic got;
    got = 1'b0;
    for (int i = 0; i < 40 && !got; i++) begin
      @(negedge ref_clk);
      got = (conv_start === 1'b1);
    end
    check(name, {31'h0, got}, 32'h1);
  endtask
  // Caller has pulled chip select low; idle means no result queued behind
  task automatic read_word(input logic [31:0] exp, input logic [12:0] cmd, input bit idle);
    cyc(4);
    check("eoc_done", {31'h0, sdo_line}, 32'h0);
    host_u.xfer(32, cmd, w);
    check("word", w, exp);
    wait_start("start_after_32");
    if (idle) begin
      cyc(4);
      check("sdo_after_32", {31'h0, sdo_line}, 32'h1);
    end
    host_u.select(1'b1);
    cyc(4);
    check("sdo_oe_idle", {31'h0, sdo_oe}, 32'h0);
  endtask
  task automatic run_row(input arsr_row_t r);
    host_u.select(1'b0);
    cyc(4);
    check("eoc_busy", {31'h0, sdo_line}, 32'h1);
    push(r.s);
    read_word(r.w, r.cmd, 1'b1);
    check("cfg", {22'h0, cfg_channel, cfg_speed}, {22'h0, r.ch, r.sp});
  endtask
  initial begin
    reset_n = 1'b0;
    res_valid = 1'b0;
    res_sample = '0;
    clock_source_select = 1'b0;
    n_fail = 0;
    compares = 0;
    repeat (20) @(posedge ref_clk);
    check("rst_sdo_oe", {31'h0, sdo_oe}, 32'h0);
    check("rst_sck_oe", {31'h0, sck_oe}, 32'h0);
    check("rst_ready", {31'h0, res_ready}, 32'h1);
    check("rst_cfg", {22'h0, cfg_channel, cfg_speed}, 32'h0);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    #1;
    check("por_start", {31'h0, conv_start}, 32'h1);
    foreach (rows[i]) run_row(rows[i]);
    check("upd_rows", n_upd, 32'h2);
    // Abort after 13 bits: new conversion, settings taken
    host_u.select(1'b0);
    push(30'h0000_1234);
    cyc(4);
    host_u.xfer(13, 13'h14A9, w);
    check("abort_bits", {19'h0, w[12:0]}, 32'h0000_0400);
    host_u.select(1'b1);
    wait_start("abort_start");
    cyc(4);
    check("abort_cfg", {22'h0, cfg_channel, cfg_speed}, {22'h0, 5'h05, 5'h09});
    check("upd_abort", n_upd, 32'h3);
    // Fill buffer until it refuses, clock with chip select high, then drain
    push(30'h0000_0001);
    push(30'h0000_0002);
    push(30'h0000_0003);
    @(negedge ref_clk);
    check("buf_full", {31'h0, res_ready}, 32'h0);
    host_u.xfer(5, 13'h1FFF, w);
    host_u.select(1'b0);
    read_word(32'h2000_0001, 13'h0000, 1'b0);
    host_u.select(1'b0);
    read_word(32'h2000_0002, 13'h0000, 1'b0);
    host_u.select(1'b0);
    read_word(32'h2000_0003, 13'h0000, 1'b1);
    // Own serial clock
    @(posedge ref_clk);
    clock_source_select <= 1'b1;
    host_u.select(1'b0);
    cyc(4);
    check("own_sck_oe", {31'h0, sck_oe}, 32'h1);
    fork
      push(30'h3FFF_FFE0);
      host_u.xfer(32, 13'h0000, w);
    join
    check("own_word", w, 32'h1FFF_FFE0);
    wait_start("own_start");
    host_u.select(1'b1);
    cyc(4);
    check("upd_end", n_upd, 32'h3);
    // Reset in mid-run: settings cleared, power-up conversion again
    host_u.select(1'b0);
    @(posedge ref_clk);
    reset_n <= 1'b0;
    clock_source_select <= 1'b0;
    cyc(2);
    check("mid_rst_oe", {31'h0, sdo_oe}, 32'h0);
    check("mid_rst_cfg", {22'h0, cfg_channel, cfg_speed}, 32'h0);
    @(posedge ref_clk);
    reset_n <= 1'b1;
    wait_start("mid_rst_start");
    cyc(4);
    check("mid_rst_eoc", {31'h0, sdo_line}, 32'h1);
    host_u.select(1'b1);
    cyc(4);
    finish_test();
  end
endmodule
`default_nettype wire
